// file: design/sdc_host.sv
/*
 * Serial host end: APB-programmed frame engine with byte buffers.
 * Assumes one target or a chain on the link; pins asynchronous.
 */
`timescale 1ns/100ps
module sdc_host
	import sdc_pkg::*;
(
	input  wire logic        CLOCK,
	input  wire logic        SYS_RST,
	sdc_if.host              LINK,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);
	import sdc_pkg::*;

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	logic [7:0]  tx_mem [HOST_BYTES];
	logic [7:0]  rx_mem [HOST_BYTES];
	logic [7:0]  nbytes_ff;
	logic        sleep_ff, en_ff, start, busy, hit_data, mapped;
	sdc_hstate_t st_ff;

	assign busy     = (st_ff != HS_IDLE);
	assign hit_data = (PADDR[11:9] == APB_DATA[11:9]) && PADDR[1:0] == 2'h0;
	assign mapped   = hit_data || PADDR == APB_CTRL || PADDR == APB_STAT;
	assign PREADY   = 1'h1;
	assign PSLVERR  = PSEL & PENABLE & ~mapped;
	assign start    = PSEL & PENABLE & PWRITE & (PADDR == APB_CTRL)
	                & PWDATA[CTRL_START] & ~busy & (PWDATA[15:8] != 8'h00)
	                & (PWDATA[15:8] <= 8'(HOST_BYTES));

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL & ~PENABLE) begin
			if (hit_data) begin
				PRDATA <= {24'h00_0000, rx_mem[PADDR[8:2]]};
			end else if (PADDR == APB_CTRL) begin
				PRDATA <= {16'h0000, nbytes_ff, 5'h00, en_ff, sleep_ff, 1'h0};
			end else if (PADDR == APB_STAT) begin
				PRDATA <= {31'h0000_0000, busy};
			end else begin
				PRDATA <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			nbytes_ff <= 8'h00;
			sleep_ff  <= 1'h0;
			en_ff     <= 1'h0;
		end else if (PSEL & PENABLE & PWRITE & (PADDR == APB_CTRL)) begin
			sleep_ff <= PWDATA[CTRL_SLEEP];
			en_ff    <= PWDATA[CTRL_EN];
			if (!busy) begin
				nbytes_ff <= PWDATA[15:8];
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (PSEL & PENABLE & PWRITE & hit_data) begin
			tx_mem[PADDR[8:2]] <= PWDATA[7:0];
		end
	end

	// ---------------------------------------------------------------
	// Frame engine
	// ---------------------------------------------------------------
	logic        sdo_s, tick;
	logic [3:0]  div_ff;
	logic [10:0] txb_ff, rxb_ff, total;
	logic [7:0]  rxsh_ff;
	logic [4:0]  gap_ff;
	logic        sclk_ff, cs_ff, sdi_ff, sample;

	sdc_pin_sync #(.W(1), .RST(1'h1)) u_sync (
		.clk (CLOCK),
		.rst (SYS_RST),
		.d   (LINK.sdo_oe ? LINK.sdo : 1'h1),
		.q   (sdo_s)
	);

	assign total  = {nbytes_ff, 3'h0};
	assign tick   = (div_ff == 4'(SCLK_HALF_CYC - 1));
	// Sample a full period after the target's drive edge, since its
	// answer reaches us through two synchronisers
	assign sample = tick & (st_ff == HS_LOW || st_ff == HS_TRAIL);

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			div_ff <= 4'h0;
		end else begin
			div_ff <= (tick || st_ff == HS_IDLE) ? 4'h0 : div_ff + 4'h1;
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_ff   <= HS_IDLE;
			sclk_ff <= 1'h0;
			cs_ff   <= 1'h1;
			sdi_ff  <= 1'h0;
			txb_ff  <= 11'h000;
			gap_ff  <= 5'h00;
		end else begin
			unique case (st_ff)
				HS_IDLE: begin
					txb_ff <= 11'h000;
					if (start) begin
						cs_ff <= 1'h0;
						st_ff <= HS_LEAD;
					end
				end
				HS_LEAD, HS_LOW: begin
					if (tick) begin
						sclk_ff <= 1'h1;
						sdi_ff  <= tx_mem[txb_ff[9:3]][~txb_ff[2:0]];
						txb_ff  <= txb_ff + 11'h001;
						st_ff   <= HS_HIGH;
					end
				end
				HS_HIGH: begin
					if (tick) begin
						sclk_ff <= 1'h0;
						st_ff   <= (txb_ff == total) ? HS_TRAIL : HS_LOW;
					end
				end
				HS_TRAIL: begin
					if (tick) begin
						cs_ff  <= 1'h1;
						gap_ff <= 5'h00;
						st_ff  <= HS_GAP;
					end
				end
				HS_GAP: begin
					gap_ff <= gap_ff + 5'h01;
					if (gap_ff == 5'(CS_GAP_CYC - 1)) begin
						st_ff <= HS_IDLE;
					end
				end
				default: st_ff <= HS_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rxb_ff  <= 11'h000;
			rxsh_ff <= 8'h00;
		end else if (start) begin
			rxb_ff <= 11'h000;
		end else if (sample) begin
			rxsh_ff <= {rxsh_ff[6:0], sdo_s};
			rxb_ff  <= rxb_ff + 11'h001;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (sample && rxb_ff[2:0] == 3'h7) begin
			rx_mem[rxb_ff[9:3]] <= {rxsh_ff[6:0], sdo_s};
		end
	end

	assign LINK.sclk              = sclk_ff;
	assign LINK.select_low_pin    = cs_ff;
	assign LINK.sdi               = sdi_ff;
	assign LINK.sleep_control_pin = sleep_ff;
	assign LINK.enable_pin        = en_ff;
endmodule : sdc_host

// file: design/sdc_if.sv
/*
 * Link between one host and one target (one hop of a chain).
 * Assumes the host resolves the tri-state data-out from its enable.
 */
`timescale 1ns/100ps
interface sdc_if;
	logic sclk;
	logic select_low_pin;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic sleep_control_pin;
	logic enable_pin;

	modport target (
		input  sclk,
		input  select_low_pin,
		input  sdi,
		input  sleep_control_pin,
		input  enable_pin,
		output sdo,
		output sdo_oe
	);
	modport host (
		output sclk,
		output select_low_pin,
		output sdi,
		output sleep_control_pin,
		output enable_pin,
		input  sdo,
		input  sdo_oe
	);
endinterface : sdc_if

// file: design/sdc_pin_sync.sv
/*
 * Three-stage input synchroniser; output follows once stages two
 * and three agree. Assumes inputs are asynchronous to clk.
 */
`timescale 1ns/100ps
module sdc_pin_sync #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					s1_ff[i] <= RST[i];
					s2_ff[i] <= RST[i];
					s3_ff[i] <= RST[i];
					q[i]     <= RST[i];
				end else begin
					s1_ff[i] <= d[i];
					s2_ff[i] <= s1_ff[i];
					s3_ff[i] <= s2_ff[i];
					if (s2_ff[i] == s3_ff[i]) begin
						q[i] <= s3_ff[i];
					end
				end
			end
		end
	endgenerate
endmodule : sdc_pin_sync

// file: design/sdc_pkg.sv
/*
 * Shared constants of the chained serial target and its host.
 * Assumes a single 50 MHz system clock in both ends.
 */
package sdc_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ       = 50;
	localparam int CLR_MIN_US    = 20;
	localparam int CLR_MAX_US    = 40;
	localparam int SLEEP_US      = 120;
	localparam int WAKE_US       = 50;
	localparam int CS_GAP_NS     = 500;
	localparam int CLR_MIN_CYC   = CLR_MIN_US * CLK_MHZ;
	localparam int CLR_MAX_CYC   = CLR_MAX_US * CLK_MHZ;
	localparam int SLEEP_CYC     = SLEEP_US * CLK_MHZ;
	localparam int WAKE_CYC      = WAKE_US * CLK_MHZ;
	localparam int CS_GAP_CYC    = (CS_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int SCLK_HALF_CYC = 6;
	// ---------------------------------------------------------------
	// Frame layout
	// ---------------------------------------------------------------
	localparam int          RW_POS      = 6;
	localparam int          HCLR_POS    = 5;
	localparam logic [1:0]  TAG_HEADER  = 2'h2;
	localparam logic [1:0]  TAG_STATUS  = 2'h3;
	localparam logic [7:0]  SINGLE_BYTES = 8'h02;
	// ---------------------------------------------------------------
	// Target registers
	// ---------------------------------------------------------------
	localparam logic [4:0]  REG_FAULT   = 5'h00;
	localparam logic [4:0]  REG_OUTCTL  = 5'h04;
	localparam logic [4:0]  REG_CLRCTL  = 5'h06;
	localparam int          OUT_EN_POS  = 7;
	localparam int          CLR_POS     = 7;
	localparam logic [7:0]  REG_RESET   = 8'h00;
	// ---------------------------------------------------------------
	// Host registers (APB)
	// ---------------------------------------------------------------
	localparam logic [11:0] APB_CTRL    = 12'h000;
	localparam logic [11:0] APB_STAT    = 12'h004;
	localparam logic [11:0] APB_DATA    = 12'h200;
	localparam int          CTRL_START  = 0;
	localparam int          CTRL_SLEEP  = 1;
	localparam int          CTRL_EN     = 2;
	localparam int          HOST_BYTES  = 128;

	typedef enum logic [2:0] {
		HS_IDLE  = 3'h0,
		HS_LEAD  = 3'h1,
		HS_HIGH  = 3'h2,
		HS_LOW   = 3'h3,
		HS_TRAIL = 3'h4,
		HS_GAP   = 3'h5
	} sdc_hstate_t;
endpackage : sdc_pkg

// file: design/sdc_target.sv
/*
 * Serial target end: 16-bit frames and chained frames, register
 * file, fault latching, sleep pulse handling and bridge gating.
 * Assumes link pins arrive asynchronously and are resynchronised.
 */
// Operation
// - Bridge on only if sleep, enable, bit high
// - Active after wake; host waits wake time
// - Sleep low 20-40 us clears faults
// - Sleep low 40-120 us clears, no shutdown
// - Sleep pulse clears all latched faults
// - Command: 0, rw, address, x, data
// - Reply: 11, six fault flags, report
// - Write reports old register content
// - Read reports current register content
// - Clock low at both select edges
// - Select high at least 500 ns
// - Deselected: ignore inputs, data-out released
// - Capture falling, drive rising, MSB first
// - Wrong clock count discards the frame
// - Chain: headers, N addresses, N data
// - Chain reply: statuses, headers, reports
// - Six-bit chain length, up to 63
// - Header clear bit clears at select rise
// - Headers start 1,0; low bits free
// - Inserted status byte starts 1,1
// - Position from statuses, own bytes only
// - Chain bytes match single-frame layout
// - Protocol error latches, pulls fault pin
`timescale 1ns/100ps
module sdc_target
	import sdc_pkg::*;
#(
	parameter int SLEEP_CYCLES = sdc_pkg::SLEEP_CYC
) (
	input  wire logic        CLOCK,
	input  wire logic        SYS_RST,
	sdc_if.target            LINK,
	input  wire logic [5:0]  FAULT_EVENTS,
	output logic             BRIDGE_EN,
	output logic             FAULT_OUT_O,
	output logic             FAULT_OUT_OE,
	output logic             AWAKE
);
	import sdc_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers and edges
	// ---------------------------------------------------------------
	logic [4:0] pins_s;
	logic       sclk_s, cs_s, sdi_s, slp_s, en_s;
	logic       sclk_d_ff, cs_d_ff, slp_d_ff;
	logic       asleep_ff, frame_ff;

	sdc_pin_sync #(.W(5), .RST(5'h08)) u_sync (
		.clk (CLOCK),
		.rst (SYS_RST),
		.d   ({LINK.sclk, LINK.select_low_pin, LINK.sdi,
		       LINK.sleep_control_pin, LINK.enable_pin}),
		.q   (pins_s)
	);
	assign {sclk_s, cs_s, sdi_s, slp_s, en_s} = pins_s;

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sclk_d_ff <= 1'h0;
			cs_d_ff   <= 1'h1;
			slp_d_ff  <= 1'h0;
		end else begin
			sclk_d_ff <= sclk_s;
			cs_d_ff   <= cs_s;
			slp_d_ff  <= slp_s;
		end
	end

	logic cs_fall, cs_rise, sck_fall, sck_rise;
	assign cs_fall  = cs_d_ff & ~cs_s & ~asleep_ff;
	assign cs_rise  = frame_ff & cs_s;
	assign sck_fall = frame_ff & ~cs_s & sclk_d_ff & ~sclk_s;
	assign sck_rise = frame_ff & ~cs_s & ~sclk_d_ff & sclk_s;

	// ---------------------------------------------------------------
	// Sleep pin: reset pulse, sleep entry, wake time
	// ---------------------------------------------------------------
	logic [12:0] low_cnt_ff;
	logic [11:0] wake_cnt_ff;
	logic        pulse_clr, wake_exit;

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			low_cnt_ff <= 13'h0000;
		end else if (slp_s) begin
			low_cnt_ff <= 13'h0000;
		end else if (low_cnt_ff != 13'(SLEEP_CYCLES)) begin
			low_cnt_ff <= low_cnt_ff + 13'h0001;
		end
	end

	// Anything longer than the short pulse also clears; the sleep
	// decision is left to the 120 us counter alone.
	assign pulse_clr = slp_s & ~slp_d_ff & ~asleep_ff
	                 & (low_cnt_ff > 13'(CLR_MIN_CYC));
	assign wake_exit = asleep_ff & slp_s
	                 & (wake_cnt_ff == 12'(WAKE_CYC - 1));

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			asleep_ff   <= 1'h1;
			wake_cnt_ff <= 12'h000;
		end else begin
			if (~slp_s && low_cnt_ff == 13'(SLEEP_CYCLES - 1)) begin
				asleep_ff <= 1'h1;
			end else if (wake_exit) begin
				asleep_ff <= 1'h0;
			end
			wake_cnt_ff <= (asleep_ff & slp_s & ~wake_exit) ?
			               wake_cnt_ff + 12'h001 : 12'h000;
		end
	end
	assign AWAKE = ~asleep_ff;

	// ---------------------------------------------------------------
	// Registers and faults
	// ---------------------------------------------------------------
	logic [7:0] regs_ff [32];
	logic [5:0] flags_ff;
	logic       perr_ff;
	logic [7:0] status_byte, fault_byte;
	logic       clr_all, wr_commit, frame_ok, perr_set;
	logic [7:0] cmd_ff, data_ff;
	logic       hclr_ff, chain_ff;

	assign status_byte = {TAG_STATUS, flags_ff};
	assign fault_byte  = {perr_ff | (|flags_ff), perr_ff, flags_ff};

	function automatic logic [7:0] rd_reg(input logic [4:0] a);
		rd_reg = (a == REG_FAULT) ? fault_byte : regs_ff[a];
	endfunction : rd_reg

	assign wr_commit = cs_rise & frame_ok & ~cmd_ff[RW_POS];
	assign clr_all   = pulse_clr | wake_exit
	                 | (cs_rise & frame_ok & chain_ff & hclr_ff)
	                 | (wr_commit && cmd_ff[5:1] == REG_CLRCTL
	                    && data_ff[CLR_POS]);

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			for (int i = 0; i < 32; i++) begin
				regs_ff[i] <= REG_RESET;
			end
		end else if (asleep_ff) begin
			for (int i = 0; i < 32; i++) begin
				regs_ff[i] <= REG_RESET;
			end
		end else if (wr_commit && cmd_ff[5:1] != REG_FAULT
		             && cmd_ff[5:1] != REG_CLRCTL) begin
			regs_ff[cmd_ff[5:1]] <= data_ff;
		end
	end

	// Set wins over clear so no event is lost
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			flags_ff <= 6'h00;
			perr_ff  <= 1'h0;
		end else begin
			flags_ff <= (clr_all ? 6'h00 : flags_ff) | FAULT_EVENTS;
			perr_ff  <= (clr_all ? 1'h0 : perr_ff) | perr_set;
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			BRIDGE_EN    <= 1'h0;
			FAULT_OUT_OE <= 1'h0;
		end else begin
			BRIDGE_EN    <= slp_s & en_s & ~asleep_ff
			              & regs_ff[REG_OUTCTL][OUT_EN_POS];
			FAULT_OUT_OE <= perr_ff | (|flags_ff);
		end
	end
	assign FAULT_OUT_O = 1'h0;

	// ---------------------------------------------------------------
	// Serial engine
	// ---------------------------------------------------------------
	logic [2:0] bit_ff;
	logic [7:0] rx_ff, tx_ff, byte_ff;
	logic [6:0] rel_ff;
	logic [5:0] pos_ff, nlen_ff, own_idx;
	logic       header_byte_one_ff, header_byte_two_ff, have_cmd_ff, have_data_ff;
	logic       ferr_ff, sdo_ff, byte_done, single_now;
	logic       own_addr, own_data, tag_err;
	logic [7:0] nxt_rx, chain_bytes;

	assign nxt_rx     = {rx_ff[6:0], sdi_s};
	assign byte_done  = sck_fall & (bit_ff == 3'h7);
	assign single_now = (byte_ff == 8'h00) ? ~nxt_rx[7] : ~chain_ff;
	assign own_idx    = nlen_ff - pos_ff - 6'h01;
	assign own_addr   = single_now ? (byte_ff == 8'h00)
	                  : (header_byte_two_ff && rel_ff == {1'h0, own_idx});
	assign own_data   = single_now ? (byte_ff == 8'h01)
	                  : (header_byte_two_ff && rel_ff == {1'h0, nlen_ff}
	                                        + {1'h0, own_idx});
	assign tag_err    = byte_done & ~single_now & ~header_byte_two_ff
	                  & (header_byte_one_ff ? nxt_rx[7:6] != TAG_HEADER
	                             : ~nxt_rx[7]);
	assign chain_bytes = {1'h0, nlen_ff, 1'h0} + SINGLE_BYTES;
	assign frame_ok   = ~ferr_ff & ~sclk_s & (bit_ff == 3'h0)
	                  & have_cmd_ff & have_data_ff
	                  & (chain_ff ? (header_byte_two_ff && pos_ff < nlen_ff
	                                 && byte_ff == chain_bytes)
	                              : (byte_ff == SINGLE_BYTES));
	assign perr_set   = cs_rise & ~frame_ok;

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			frame_ff     <= 1'h0;
			bit_ff       <= 3'h0;
			byte_ff      <= 8'h00;
			rx_ff        <= 8'h00;
			tx_ff        <= 8'h00;
			sdo_ff       <= 1'h0;
			rel_ff       <= 7'h00;
			pos_ff       <= 6'h00;
			nlen_ff      <= 6'h00;
			header_byte_one_ff      <= 1'h0;
			header_byte_two_ff      <= 1'h0;
			hclr_ff      <= 1'h0;
			chain_ff     <= 1'h0;
			cmd_ff       <= 8'h00;
			data_ff      <= 8'h00;
			have_cmd_ff  <= 1'h0;
			have_data_ff <= 1'h0;
			ferr_ff      <= 1'h0;
		end else if (cs_fall) begin
			frame_ff     <= 1'h1;
			bit_ff       <= 3'h0;
			byte_ff      <= 8'h00;
			rel_ff       <= 7'h00;
			pos_ff       <= 6'h00;
			header_byte_one_ff      <= 1'h0;
			header_byte_two_ff      <= 1'h0;
			hclr_ff      <= 1'h0;
			chain_ff     <= 1'h0;
			have_cmd_ff  <= 1'h0;
			have_data_ff <= 1'h0;
			ferr_ff      <= sclk_s;
			tx_ff        <= status_byte;
			sdo_ff       <= 1'h1;
		end else if (cs_rise || asleep_ff) begin
			frame_ff <= 1'h0;
		end else if (sck_rise) begin
			sdo_ff <= tx_ff[7];
			tx_ff  <= {tx_ff[6:0], 1'h0};
		end else if (sck_fall) begin
			bit_ff <= bit_ff + 3'h1;
			rx_ff  <= nxt_rx;
			if (byte_done) begin
				if (byte_ff != 8'hff) begin
					byte_ff <= byte_ff + 8'h01;
				end
				if (byte_ff == 8'h00) begin
					chain_ff <= nxt_rx[7];
				end
				// Own address slot goes back out as the report
				tx_ff <= own_addr ? rd_reg(nxt_rx[5:1]) : nxt_rx;
				if (own_addr) begin
					cmd_ff      <= nxt_rx;
					have_cmd_ff <= 1'h1;
				end
				if (own_data) begin
					data_ff      <= nxt_rx;
					have_data_ff <= 1'h1;
				end
				if (tag_err) begin
					ferr_ff <= 1'h1;
				end
				if (!single_now) begin
					if (!header_byte_one_ff) begin
						if (nxt_rx[7:6] == TAG_STATUS) begin
							pos_ff <= pos_ff + 6'h01;
						end else if (nxt_rx[7:6] == TAG_HEADER) begin
							header_byte_one_ff <= 1'h1;
							nlen_ff <= nxt_rx[5:0];
						end
					end else if (!header_byte_two_ff) begin
						header_byte_two_ff <= 1'h1;
						hclr_ff <= nxt_rx[HCLR_POS];
					end else if (rel_ff != 7'h7f) begin
						rel_ff <= rel_ff + 7'h01;
					end
				end
			end
		end
	end

	assign LINK.sdo    = sdo_ff;
	assign LINK.sdo_oe = frame_ff;
endmodule : sdc_target

// file: sim/sdc_link_properties.sv
/*
 * Assertions on the link wires between host and target.
 * Assumes it is instantiated beside the link that joins them.
 */
`timescale 1ns/100ps
module sdc_link_properties
	import sdc_pkg::*;
(
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic sclk,
	input wire logic select_low_pin,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic       sclk_ff;
	logic [7:0] bits_ff;
	logic [5:0] gap_ff;

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);

	// ---------------------------------------------------------------
	// Frame bookkeeping
	// ---------------------------------------------------------------
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sclk_ff <= 1'b0;
			bits_ff <= 8'h00;
		end else begin
			sclk_ff <= sclk;
			if (select_low_pin) begin
				bits_ff <= 8'h00;
			end else if (sclk_ff && !sclk) begin
				bits_ff <= bits_ff + 8'h01;
			end
		end
	end
	// Saturates so that a long idle span cannot wrap to a short one
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			gap_ff <= 6'h00;
		end else if (!select_low_pin) begin
			gap_ff <= 6'h00;
		end else if (gap_ff != 6'h3F) begin
			gap_ff <= gap_ff + 6'h01;
		end
	end

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	sequence s_open;
		$fell(select_low_pin) ##0 !sclk;
	endsequence
	sequence s_close;
		$rose(select_low_pin) ##0 !sclk;
	endsequence

	a_sclk_open: assert property (
		$fell(select_low_pin) |-> !sclk)
		else $error("clock high at select fall");
	a_sclk_close: assert property (
		$rose(select_low_pin) |-> s_close)
		else $error("clock high at select rise");
	a_select_gap: assert property (
		$fell(select_low_pin) |-> gap_ff >= 6'(CS_GAP_CYC))
		else $error("select gap too short");
	a_sdo_release: assert property (
		s_close |-> ##[1:8] !sdo_oe)
		else $error("data out not released");
	a_sdo_drive: assert property (
		s_open |-> ##[1:8] sdo_oe)
		else $error("data out not driven");
	a_sdo_settled: assert property (
		$fell(sclk) && sdo_oe |-> $stable(sdo) [*3])
		else $error("data out moved at capture");
	a_sdi_on_rise: assert property (
		!select_low_pin && $changed(sdi) |-> $rose(sclk))
		else $error("data in moved off rise");
	a_status_ones: assert property (
		$fell(sclk) && bits_ff < 8'h02 |-> sdo)
		else $error("status byte top bits not ones");
	a_whole_bytes: assert property (
		$rose(select_low_pin) |-> bits_ff[2:0] == 3'h0)
		else $error("frame not whole bytes");
endmodule : sdc_link_properties

// file: sim/sdc_tb_top.sv
/*
 * Bench: host and target on one link, host driven over APB.
 * Assumes the target wakes within WAKE_CYC + 20 cycles of the sleep pin rising.
 */
`timescale 1ns/100ps
module sdc_tb_top;
	import sdc_pkg::*;
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [5:0]  fault_ev = 6'h00;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        bridge_en;
	logic        flt_oe;
	logic        flt_o;
	logic        awake;
	logic [31:0] q;
	logic        err;
	int          fails = 0;
	int          compares = 0;

	always #10 clock = ~clock;

	sdc_if i_sdc_if ();
	sdc_host i_sdc_host (.CLOCK(clock), .SYS_RST(sys_rst),
		.LINK(i_sdc_if.host), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	// Short sleep count keeps the run brief, yet above the clear pulse
	sdc_target #(.SLEEP_CYCLES(3000)) i_sdc_target (.CLOCK(clock),
		.SYS_RST(sys_rst), .LINK(i_sdc_if.target),
		.FAULT_EVENTS(fault_ev), .BRIDGE_EN(bridge_en),
		.FAULT_OUT_O(flt_o), .FAULT_OUT_OE(flt_oe), .AWAKE(awake));
	sdc_link_properties i_sdc_link_properties (.CLOCK(clock),
		.SYS_RST(sys_rst), .sclk(i_sdc_if.sclk),
		.select_low_pin(i_sdc_if.select_low_pin),
		.sdi(i_sdc_if.sdi), .sdo(i_sdc_if.sdo),
		.sdo_oe(i_sdc_if.sdo_oe));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic test_done();
		if (fails == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : test_done

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic ctrl(input logic [7:0] len, input logic [1:0] pins,
		input logic go);
		apb(1'b1, APB_CTRL, {16'h0000, len, 5'h00, pins, go});
	endtask : ctrl

	// Bytes sit most significant first in tx and rx
	task automatic frame(input int n, input logic [31:0] tx,
		input int m, input logic [31:0] rx);
		for (int i = 0; i < n; i++) begin
			apb(1'b1, APB_DATA + 12'(4 * i), {24'h0, tx[31 - 8 * i -: 8]});
		end
		ctrl(8'(n), 2'b11, 1'b1);
		apb(1'b0, APB_STAT, 32'h0000_0000);
		while (q[0] !== 1'b0) begin
			apb(1'b0, APB_STAT, 32'h0000_0000);
		end
		for (int i = 0; i < m; i++) begin
			apb(1'b0, APB_DATA + 12'(4 * i), 32'h0000_0000);
			chk("rx byte", q, {24'h0, rx[31 - 8 * i -: 8]});
		end
	endtask : frame

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_wake();
		ctrl(8'h00, 2'b11, 1'b0);
		repeat (WAKE_CYC + 20) @(posedge clock);
		chk("awake", awake, 1'b1);
		apb(1'b0, 12'h100, 32'h0000_0000);
		chk("unmapped err", err, 1'b1);
		chk("unmapped data", q, 32'h0000_0000);
	endtask : t_wake

	task automatic t_write_read();
		frame(2, 32'h0880_0000, 2, 32'hC000_0000);
		chk("bridge on", bridge_en, 1'b1);
		frame(2, 32'h4800_0000, 2, 32'hC080_0000);
		ctrl(8'h00, 2'b01, 1'b0);
		repeat (20) @(posedge clock);
		chk("bridge off", bridge_en, 1'b0);
		ctrl(8'h00, 2'b11, 1'b0);
	endtask : t_write_read

	task automatic t_chain_clear();
		fault_ev <= 6'h08;
		@(posedge clock);
		fault_ev <= 6'h00;
		repeat (20) @(posedge clock);
		chk("fault pin", flt_oe, 1'b1);
		chk("fault level", flt_o, 1'b0);
		frame(4, 32'h81A0_4800, 4, 32'hC881_A080);
		// Same frame also exercises
		chk("header clear", flt_oe, 1'b0);
	endtask : t_chain_clear

	task automatic t_frame_error();
		frame(3, 32'h0A55_0000, 2, 32'hC000_0000);
		chk("proto fault", flt_oe, 1'b1);
		frame(2, 32'h4A00_0000, 2, 32'hC000_0000);
		frame(2, 32'h4000_0000, 2, 32'hC0C0_0000);
	endtask : t_frame_error

	// Low for about 30 us: clears faults without sleeping
	task automatic t_sleep_pulse();
		ctrl(8'h00, 2'b10, 1'b0);
		repeat (750) @(posedge clock);
		chk("bridge in pulse", bridge_en, 1'b0);
		repeat (750) @(posedge clock);
		ctrl(8'h00, 2'b11, 1'b0);
		repeat (20) @(posedge clock);
		chk("pulse clear", flt_oe, 1'b0);
		chk("still awake", awake, 1'b1);
		frame(2, 32'h4800_0000, 2, 32'hC080_0000);
	endtask : t_sleep_pulse

	// Low for about 50 us: still clears, device stays up
	task automatic t_long_pulse();
		fault_ev <= 6'h01;
		ctrl(8'h00, 2'b10, 1'b0);
		fault_ev <= 6'h00;
		repeat (2500) @(posedge clock);
		chk("long fault held", flt_oe, 1'b1);
		ctrl(8'h00, 2'b11, 1'b0);
		repeat (20) @(posedge clock);
		chk("long pulse clear", flt_oe, 1'b0);
		chk("long pulse awake", awake, 1'b1);
	endtask : t_long_pulse

	initial begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		t_wake();
		t_write_read();
		t_chain_clear();
		t_frame_error();
		t_sleep_pulse();
		t_long_pulse();
		test_done();
	end

	initial begin
		repeat (40000) @(posedge clock);
		fails++;
		test_done();
	end
endmodule : sdc_tb_top
